// file: hdl/ssc_pkg.sv
package ssc_pkg;

   // ************************************************************
   // command code byte layout
   // ************************************************************
   localparam int         CC_FUNC_LSB  = 2;
   localparam int         CC_FUNC_W    = 3;
   localparam int         CC_SIZE_LSB  = 5;
   localparam int         CC_SIZE_W    = 2;
   localparam logic [2:0] FUNC_CSR     = 3'h0;
   localparam logic [2:0] FUNC_EE      = 3'h1;
   localparam logic [1:0] SIZE_BLOCK   = 2'h2;
   localparam logic [1:0] SIZE_RSV     = 2'h3;

   // ************************************************************
   // register command byte layout
   // ************************************************************
   localparam int         CSR_BE_LSB   = 0;
   localparam int         CSR_BE_W     = 4;
   localparam int         CSR_OP_BIT   = 4;
   localparam int         CSR_READ_UNCLAIMED_FLAG_BIT = 6;
   localparam int         CSR_WRITE_UNCLAIMED_FLAG_BIT = 7;
   localparam int         ADDR_LO_W    = 8;
   localparam int         ADDR_HI_W    = 6;
   localparam int         REG_ADDR_W   = ADDR_LO_W + ADDR_HI_W;

   // ************************************************************
   // eeprom command byte layout
   // ************************************************************
   localparam int         EE_OP_BIT    = 0;
   localparam int         EE_USA_BIT   = 1;
   localparam int         EE_UNEXPECTED_NACK_FLAG_BIT = 3;
   localparam int         EE_OTHER_BIT = 5;
   localparam int         EE_DEV_W     = 7;

   // ************************************************************
   // bytes that follow the length byte, per operation
   // ************************************************************
   localparam logic [7:0] CSR_WR_LEN   = 8'h07;
   localparam logic [7:0] CSR_RD_LEN   = 8'h03;
   localparam logic [7:0] EE_WR_LEN    = 8'h05;
   localparam logic [7:0] EE_RD_LEN    = 8'h04;
   localparam int         BODY_MAX     = 7;

   typedef enum {SSC_LK_CODE, SSC_LK_COUNT, SSC_LK_BODY} ssc_lk_e;
   typedef enum {SSC_IDLE, SSC_CSR, SSC_EE, SSC_RESP} ssc_core_e;

   typedef struct packed {
      logic                  is_ee;
      logic                  wr;
      logic                  bad;
      logic                  use_dev;
      logic [CSR_BE_W-1:0]   be;
      logic [15:0]           addr;
      logic [31:0]           wdata;
      logic [EE_DEV_W-1:0]   dev;
   } ssc_req_s;

   typedef struct packed {
      logic [7:0]            status;
      logic [31:0]           rdata;
   } ssc_rsp_s;

endpackage

// file: hdl/ssc_sync.sv
`timescale 1ns/100ps
// two-flop level synchroniser; only stage two is read outside
module ssc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// file: hdl/ssc_hs_xfer.sv
`timescale 1ns/100ps
// toggle handshake word crossing; data held stable while in flight
module ssc_hs_xfer #(
   parameter int W = 8
) (
   input  wire logic         src_clk,
   input  wire logic         src_rst,
   input  wire logic         src_valid,
   input  wire logic [W-1:0] src_data,
   output logic              src_busy,
   input  wire logic         dst_clk,
   input  wire logic         dst_rst,
   output logic              dst_valid,
   output logic      [W-1:0] dst_data
);
   logic         req_tgl_r;
   logic         ack_tgl_r;
   logic         ack_s;
   logic         req_s;
   logic [W-1:0] hold_r;

   // source side: new word only once the last one was seen
   always_ff @(posedge src_clk) begin
      if (src_rst) begin
         req_tgl_r <= 1'b0;
         hold_r    <= '0;
      end else if (src_valid && !src_busy) begin
         req_tgl_r <= ~req_tgl_r;
         hold_r    <= src_data;
      end
   end

   assign src_busy = req_tgl_r ^ ack_s;

   ssc_sync #(.W(1)) u_req_sync (
      .clk (dst_clk),
      .rst (dst_rst),
      .d   (req_tgl_r),
      .q   (req_s)
   );

   ssc_sync #(.W(1)) u_ack_sync (
      .clk (src_clk),
      .rst (src_rst),
      .d   (ack_tgl_r),
      .q   (ack_s)
   );

   // destination side: a toggle edge means hold_r is settled
   always_ff @(posedge dst_clk) begin
      if (dst_rst) begin
         ack_tgl_r <= 1'b0;
         dst_valid <= 1'b0;
         dst_data  <= '0;
      end else begin
         dst_valid <= req_s ^ ack_tgl_r;
         ack_tgl_r <= req_s;
         if (req_s ^ ack_tgl_r) begin
            dst_data <= hold_r;
         end
      end
   end
endmodule

// file: hdl/ssc_cmd.sv
`timescale 1ns/100ps
module ssc_cmd (
   input  wire logic                         ref_clk,
   input  wire logic                         srst,
   input  wire logic                         link_clk,
   input  wire logic                         lk_valid,
   input  wire logic [7:0]                   lk_data,
   input  wire logic                         lk_stop,
   output logic                              lk_busy,
   output logic                              lk_nack,
   output logic                              lk_resp_valid,
   output logic      [7:0]                   lk_status,
   output logic      [31:0]                  lk_rdata,
   output logic                              reg_req,
   output logic                              reg_wr,
   output logic      [ssc_pkg::REG_ADDR_W-1:0] reg_addr,
   output logic      [ssc_pkg::CSR_BE_W-1:0] reg_be,
   output logic      [31:0]                  reg_wdata,
   input  wire logic                         reg_ack,
   input  wire logic                         reg_claimed,
   input  wire logic [31:0]                  reg_rdata,
   output logic                              ee_req,
   output logic                              ee_rd,
   output logic      [ssc_pkg::EE_DEV_W-1:0] ee_dev_addr,
   output logic      [15:0]                  ee_addr,
   output logic      [7:0]                   ee_wdata,
   input  wire logic                         ee_done,
   input  wire logic                         ee_nack,
   input  wire logic                         ee_misplaced,
   input  wire logic [7:0]                   ee_rdata,
   input  wire logic [ssc_pkg::EE_DEV_W-1:0] cfg_ee_dev_addr,
   input  wire logic [1:0]                   ee_err_clr,
   output logic      [7:0]                   csr_status,
   output logic      [7:0]                   ee_status
);

   // ************************************************************
   // link domain reset and byte parsing
   // ************************************************************
   logic                lk_rst;
   ssc_pkg::ssc_lk_e    lk_st_r;
   logic [7:0]          code_r;
   logic [7:0]          cnt_r;
   logic [3:0]          n_r;
   logic [7:0]          body_r [ssc_pkg::BODY_MAX];
   logic [2:0]          func;
   logic [1:0]          size;
   logic                rd_op;
   logic [7:0]          exp_len;
   logic                form_ok;
   logic                req_busy;
   logic                send;
   ssc_pkg::ssc_req_s   lk_req;
   logic                rsp_in;
   ssc_pkg::ssc_rsp_s   rsp_in_data;

   // body length expected after the length byte
   function automatic logic [7:0] body_len(input logic [2:0] f,
                                           input logic       rd);
      if (f == ssc_pkg::FUNC_EE) begin
         body_len = rd ? ssc_pkg::EE_RD_LEN : ssc_pkg::EE_WR_LEN;
      end else begin
         body_len = rd ? ssc_pkg::CSR_RD_LEN : ssc_pkg::CSR_WR_LEN;
      end
   endfunction

   // no reset on this stage: it is what makes the link reset
   ssc_sync #(.W(1)) u_rst_sync (
      .clk (link_clk),
      .rst (1'b0),
      .d   (srst),
      .q   (lk_rst)
   );

   // frame position: code, optional length, then body bytes
   always_ff @(posedge link_clk) begin
      if (lk_rst) begin
         lk_st_r <= ssc_pkg::SSC_LK_CODE;
         code_r  <= 8'h00;
         cnt_r   <= 8'h00;
         n_r     <= 4'h0;
      end else if (lk_stop) begin
         lk_st_r <= ssc_pkg::SSC_LK_CODE;
      end else if (lk_valid) begin
         case (lk_st_r)
            ssc_pkg::SSC_LK_CODE: begin
               code_r <= lk_data;
               n_r    <= 4'h0;
               // length byte only for block transfers
               if (lk_data[ssc_pkg::CC_SIZE_LSB +: ssc_pkg::CC_SIZE_W]
                   == ssc_pkg::SIZE_BLOCK) begin
                  lk_st_r <= ssc_pkg::SSC_LK_COUNT;
               end else begin
                  lk_st_r <= ssc_pkg::SSC_LK_BODY;
               end
            end
            ssc_pkg::SSC_LK_COUNT: begin
               cnt_r   <= lk_data;
               lk_st_r <= ssc_pkg::SSC_LK_BODY;
            end
            ssc_pkg::SSC_LK_BODY: begin
               // saturate so an overlong frame never looks right
               if (n_r != 4'hf) begin
                  n_r <= n_r + 4'h1;
               end
            end
            default: lk_st_r <= ssc_pkg::SSC_LK_CODE;
         endcase
      end
   end

   // body bytes stored in arrival order
   always_ff @(posedge link_clk) begin
      if (lk_rst) begin
         for (int i = 0; i < ssc_pkg::BODY_MAX; i++) begin
            body_r[i] <= 8'h00;
         end
      end else if (lk_valid && !lk_stop &&
                   lk_st_r == ssc_pkg::SSC_LK_BODY &&
                   n_r < 4'(ssc_pkg::BODY_MAX)) begin
         body_r[n_r[2:0]] <= lk_data;
      end
   end

   // form check on the collected frame
   always_comb begin
      func    = code_r[ssc_pkg::CC_FUNC_LSB +: ssc_pkg::CC_FUNC_W];
      size    = code_r[ssc_pkg::CC_SIZE_LSB +: ssc_pkg::CC_SIZE_W];
      rd_op   = (func == ssc_pkg::FUNC_EE) ?
                body_r[0][ssc_pkg::EE_OP_BIT] :
                body_r[0][ssc_pkg::CSR_OP_BIT];
      exp_len = body_len(func, rd_op);
      form_ok = (func == ssc_pkg::FUNC_CSR || func == ssc_pkg::FUNC_EE) &&
                size != ssc_pkg::SIZE_RSV &&
                lk_st_r == ssc_pkg::SSC_LK_BODY &&
                {4'h0, n_r} == exp_len &&
                (size != ssc_pkg::SIZE_BLOCK || cnt_r == exp_len);
   end

   // request word built from body bytes
   always_comb begin
      lk_req         = '0;
      lk_req.bad     = !form_ok;
      lk_req.is_ee   = (func == ssc_pkg::FUNC_EE);
      if (func == ssc_pkg::FUNC_EE) begin
         lk_req.wr      = !body_r[0][ssc_pkg::EE_OP_BIT];
         lk_req.use_dev = body_r[0][ssc_pkg::EE_USA_BIT];
         lk_req.dev     = body_r[1][7:1];
         lk_req.addr    = {body_r[3], body_r[2]};
         lk_req.wdata   = {24'h000000, body_r[4]};
      end else begin
         lk_req.wr    = !body_r[0][ssc_pkg::CSR_OP_BIT];
         lk_req.be    = body_r[0][ssc_pkg::CSR_BE_LSB +:
                                  ssc_pkg::CSR_BE_W];
         // doubleword index: 6 high bits over 8 low bits
         lk_req.addr  = {2'b00, body_r[2][ssc_pkg::ADDR_HI_W-1:0],
                         body_r[1]};
         lk_req.wdata = {body_r[6], body_r[5], body_r[4], body_r[3]};
      end
   end

   // a frame with a body ends in a request unless one is pending
   assign send = lk_stop && lk_st_r != ssc_pkg::SSC_LK_CODE &&
                 !lk_busy && !req_busy;

   // busy tracking and refusal of frames while busy
   always_ff @(posedge link_clk) begin
      if (lk_rst) begin
         lk_busy <= 1'b0;
         lk_nack <= 1'b0;
      end else begin
         lk_nack <= lk_stop && lk_st_r != ssc_pkg::SSC_LK_CODE &&
                    (lk_busy || req_busy);
         if (send) begin
            lk_busy <= 1'b1;
         end else if (rsp_in) begin
            lk_busy <= 1'b0;
         end
      end
   end

   // reply latched for the bit engine to return to the host
   always_ff @(posedge link_clk) begin
      if (lk_rst) begin
         lk_resp_valid <= 1'b0;
         lk_status     <= 8'h00;
         lk_rdata      <= 32'h00000000;
      end else begin
         lk_resp_valid <= rsp_in;
         if (rsp_in) begin
            lk_status <= rsp_in_data.status;
            lk_rdata  <= rsp_in_data.rdata;
         end
      end
   end

   // ************************************************************
   // crossings between link and core domains
   // ************************************************************
   logic                rq_in;
   ssc_pkg::ssc_req_s   rq_data;
   logic                rsp_busy;
   logic                rsp_send;
   ssc_pkg::ssc_rsp_s   rsp_data;

   ssc_hs_xfer #(.W($bits(ssc_pkg::ssc_req_s))) u_req_xfer (
      .src_clk   (link_clk),
      .src_rst   (lk_rst),
      .src_valid (send),
      .src_data  (lk_req),
      .src_busy  (req_busy),
      .dst_clk   (ref_clk),
      .dst_rst   (srst),
      .dst_valid (rq_in),
      .dst_data  (rq_data)
   );

   ssc_hs_xfer #(.W($bits(ssc_pkg::ssc_rsp_s))) u_rsp_xfer (
      .src_clk   (ref_clk),
      .src_rst   (srst),
      .src_valid (rsp_send),
      .src_data  (rsp_data),
      .src_busy  (rsp_busy),
      .dst_clk   (link_clk),
      .dst_rst   (lk_rst),
      .dst_valid (rsp_in),
      .dst_data  (rsp_in_data)
   );

   // ************************************************************
   // core domain execution
   // ************************************************************
   ssc_pkg::ssc_core_e  st_r;
   ssc_pkg::ssc_req_s   cur_r;
   logic [31:0]         rdata_r;
   logic [7:0]          ee_status_nxt;

   // sequencer and access strobes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_r        <= ssc_pkg::SSC_IDLE;
         cur_r       <= '0;
         reg_req     <= 1'b0;
         reg_wr      <= 1'b0;
         reg_addr    <= '0;
         reg_be      <= '0;
         reg_wdata   <= 32'h00000000;
         ee_req      <= 1'b0;
         ee_rd       <= 1'b0;
         ee_dev_addr <= '0;
         ee_addr     <= 16'h0000;
         ee_wdata    <= 8'h00;
         rdata_r     <= 32'h00000000;
      end else begin
         case (st_r)
            ssc_pkg::SSC_IDLE: begin
               if (rq_in) begin
                  cur_r <= rq_data;
                  if (rq_data.bad) begin
                     st_r <= ssc_pkg::SSC_RESP;
                  end else if (rq_data.is_ee) begin
                     ee_req   <= 1'b1;
                     ee_rd    <= !rq_data.wr;
                     ee_addr  <= rq_data.addr;
                     ee_wdata <= rq_data.wdata[7:0];
                     ee_dev_addr <= rq_data.use_dev ? rq_data.dev :
                                    cfg_ee_dev_addr;
                     st_r     <= ssc_pkg::SSC_EE;
                  end else begin
                     reg_req   <= 1'b1;
                     reg_wr    <= rq_data.wr;
                     reg_addr  <= rq_data.addr[ssc_pkg::REG_ADDR_W-1:0];
                     // lane merge is done by the target per strobe
                     reg_be    <= rq_data.be;
                     reg_wdata <= rq_data.wdata;
                     st_r      <= ssc_pkg::SSC_CSR;
                  end
               end
            end
            ssc_pkg::SSC_CSR: begin
               if (reg_ack) begin
                  reg_req <= 1'b0;
                  rdata_r <= reg_rdata;
                  st_r    <= ssc_pkg::SSC_RESP;
               end
            end
            ssc_pkg::SSC_EE: begin
               if (ee_done) begin
                  ee_req  <= 1'b0;
                  rdata_r <= {24'h000000, ee_rdata};
                  st_r    <= ssc_pkg::SSC_RESP;
               end
            end
            ssc_pkg::SSC_RESP: begin
               if (!rsp_busy) begin
                  st_r <= ssc_pkg::SSC_IDLE;
               end
            end
            default: st_r <= ssc_pkg::SSC_IDLE;
         endcase
      end
   end

   // register status: each error bit tracks the last request of its kind, malformed frames included
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         csr_status <= 8'h00;
      end else if ((st_r == ssc_pkg::SSC_CSR && reg_ack) ||
                   (st_r == ssc_pkg::SSC_IDLE && rq_in &&
                    rq_data.bad && !rq_data.is_ee)) begin
         csr_status[ssc_pkg::CSR_BE_LSB +: ssc_pkg::CSR_BE_W] <=
            (st_r == ssc_pkg::SSC_CSR) ? cur_r.be : rq_data.be;
         csr_status[ssc_pkg::CSR_OP_BIT] <=
            (st_r == ssc_pkg::SSC_CSR) ? !cur_r.wr : !rq_data.wr;
         if (st_r == ssc_pkg::SSC_CSR) begin
            // after the access ran the unclaimed flag is the inverse of reg_claimed; a malformed frame sets it
            if (!cur_r.wr) begin
               csr_status[ssc_pkg::CSR_READ_UNCLAIMED_FLAG_BIT] <= !reg_claimed;
            end else begin
               csr_status[ssc_pkg::CSR_WRITE_UNCLAIMED_FLAG_BIT] <= !reg_claimed;
            end
         end else if (!rq_data.wr) begin
            csr_status[ssc_pkg::CSR_READ_UNCLAIMED_FLAG_BIT] <= 1'b1;
         end else begin
            csr_status[ssc_pkg::CSR_WRITE_UNCLAIMED_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // eeprom status: sticky errors, write one to clear, set wins
   always_comb begin
      ee_status_nxt = ee_status;
      if (st_r == ssc_pkg::SSC_IDLE && rq_in && rq_data.is_ee) begin
         ee_status_nxt[ssc_pkg::EE_OP_BIT]  = !rq_data.wr;
         ee_status_nxt[ssc_pkg::EE_USA_BIT] = rq_data.use_dev;
      end
      if (ee_err_clr[0]) begin
         ee_status_nxt[ssc_pkg::EE_UNEXPECTED_NACK_FLAG_BIT] = 1'b0;
      end
      if (ee_err_clr[1]) begin
         ee_status_nxt[ssc_pkg::EE_OTHER_BIT] = 1'b0;
      end
      if (st_r == ssc_pkg::SSC_EE && ee_done && ee_nack) begin
         ee_status_nxt[ssc_pkg::EE_UNEXPECTED_NACK_FLAG_BIT] = 1'b1;
      end
      if (st_r == ssc_pkg::SSC_EE && ee_done && ee_misplaced) begin
         ee_status_nxt[ssc_pkg::EE_OTHER_BIT] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ee_status <= 8'h00;
      end else begin
         ee_status <= ee_status_nxt;
      end
   end

   // reply: status byte of the finished command plus read data
   assign rsp_send        = (st_r == ssc_pkg::SSC_RESP);
   assign rsp_data.status = cur_r.is_ee ? ee_status : csr_status;
   assign rsp_data.rdata  = rdata_r;

   // ************************************************************
   // checks
   // ************************************************************
   a_read_unclaimed: assert property (
      @(posedge ref_clk) disable iff (srst)
      st_r == ssc_pkg::SSC_CSR && reg_ack && !cur_r.wr && !reg_claimed
      |=> csr_status[ssc_pkg::CSR_READ_UNCLAIMED_FLAG_BIT] && st_r == ssc_pkg::SSC_RESP)
      else $error("read error bit not set on unclaimed read");

   a_write_unclaimed: assert property (
      @(posedge ref_clk) disable iff (srst)
      st_r == ssc_pkg::SSC_CSR && reg_ack && cur_r.wr && !reg_claimed
      |=> csr_status[ssc_pkg::CSR_WRITE_UNCLAIMED_FLAG_BIT] && !reg_req)
      else $error("write error bit not set on unclaimed write");

   a_claim_clears: assert property (
      @(posedge ref_clk) disable iff (srst)
      st_r == ssc_pkg::SSC_CSR && reg_ack && reg_claimed
      |=> !csr_status[$past(cur_r.wr) ? ssc_pkg::CSR_WRITE_UNCLAIMED_FLAG_BIT :
                      ssc_pkg::CSR_READ_UNCLAIMED_FLAG_BIT])
      else $error("error bit stays set after claimed access");

   a_bad_no_access: assert property (
      @(posedge ref_clk) disable iff (srst)
      st_r == ssc_pkg::SSC_IDLE && rq_in && rq_data.bad
      |=> (!reg_req && !ee_req) [*2])
      else $error("malformed frame started an access");

   a_lane_strobe: assert property (
      @(posedge ref_clk) disable iff (srst)
      $rose(reg_req) |-> reg_be == cur_r.be && reg_wr == cur_r.wr &&
      reg_addr == cur_r.addr[ssc_pkg::REG_ADDR_W-1:0])
      else $error("register strobe does not match request");

   a_dev_select: assert property (
      @(posedge ref_clk) disable iff (srst)
      $rose(ee_req) |-> ee_dev_addr ==
      (cur_r.use_dev ? cur_r.dev : $past(cfg_ee_dev_addr)))
      else $error("wrong eeprom device address used");

   a_nack_wins: assert property (
      @(posedge ref_clk) disable iff (srst)
      st_r == ssc_pkg::SSC_EE && ee_done && ee_nack
      |=> ee_status[ssc_pkg::EE_UNEXPECTED_NACK_FLAG_BIT] ##1
          (ee_status[ssc_pkg::EE_UNEXPECTED_NACK_FLAG_BIT] || $past(ee_err_clr[0])))
      else $error("nack error bit lost");

   a_busy_refuse: assert property (
      @(posedge link_clk) disable iff (lk_rst)
      lk_stop && lk_busy && lk_st_r != ssc_pkg::SSC_LK_CODE
      |=> lk_nack && (lk_busy || lk_resp_valid))
      else $error("frame during busy not refused");

   a_block_len: assert property (
      @(posedge link_clk) disable iff (lk_rst)
      lk_stop && !lk_busy && !req_busy &&
      size == ssc_pkg::SIZE_BLOCK && cnt_r != exp_len &&
      lk_st_r == ssc_pkg::SSC_LK_BODY |-> lk_req.bad)
      else $error("wrong length byte accepted");

endmodule

// file: verification/ssc_host.sv
`timescale 1ns/100ps
// ****
// smbus host stand-in, byte level
// ****
module ssc_host (
   input  wire logic link_clk,
   output logic       lk_valid,
   output logic [7:0] lk_data,
   output logic       lk_stop
);
   initial begin
      lk_valid = 1'b0;
      lk_data  = 8'h00;
      lk_stop  = 1'b0;
   end
   // one frame, then stop; data inverted once released, never left stale
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(posedge link_clk);
         lk_valid <= 1'b1;
         lk_data  <= b[i];
      end
      @(posedge link_clk);
      lk_valid <= 1'b0;
      lk_data  <= ~lk_data;
      lk_stop  <= 1'b1;
      @(posedge link_clk);
      lk_stop  <= 1'b0;
   endtask
endmodule

// file: verification/tb_ssc_cmd.sv
`timescale 1ns/100ps
// ****
// bench: host frames in, register and eeprom targets answered here
// ****
module tb_ssc_cmd;
   logic        ref_clk, link_clk, srst, lk_valid, lk_stop, lk_nack;
   logic        lk_resp_valid, reg_req, reg_wr, reg_ack, ee_req, ee_rd;
   logic        reg_claimed, ee_done, ee_nack, ee_misplaced;
   logic [7:0]  lk_data, lk_status, ee_wdata, ee_rdata;
   logic [7:0]  csr_status, ee_status;
   logic        lk_busy;
   logic [31:0] lk_rdata, reg_wdata, reg_rdata;
   logic [31:0] seed = 32'h00e7b755;
   logic [13:0] reg_addr;
   logic [3:0]  reg_be;
   logic [6:0]  ee_dev_addr, cfg_ee_dev_addr;
   logic [15:0] ee_addr;
   logic [1:0]  ee_err_clr;
   logic        write_unclaimed_flag, read_unclaimed_flag, nak, oth;
   int          n_errors, samples_checked, nacks, cyc;
   ssc_host host (.link_clk(link_clk), .lk_valid(lk_valid),
      .lk_data(lk_data), .lk_stop(lk_stop));
   ssc_cmd dut (.ref_clk(ref_clk), .srst(srst), .link_clk(link_clk),
      .lk_valid(lk_valid), .lk_data(lk_data), .lk_stop(lk_stop),
      .lk_busy(lk_busy), .lk_nack(lk_nack), .lk_resp_valid(lk_resp_valid),
      .lk_status(lk_status), .lk_rdata(lk_rdata), .reg_req(reg_req),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be),
      .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_claimed(reg_claimed),
      .reg_rdata(reg_rdata), .ee_req(ee_req), .ee_rd(ee_rd),
      .ee_dev_addr(ee_dev_addr), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
      .ee_done(ee_done), .ee_nack(ee_nack), .ee_misplaced(ee_misplaced),
      .ee_rdata(ee_rdata), .cfg_ee_dev_addr(cfg_ee_dev_addr),
      .ee_err_clr(ee_err_clr), .csr_status(csr_status),
      .ee_status(ee_status));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // link clock offset so the two domains never line up
   initial begin
      link_clk = 1'b0;
      #7.3;
      forever #40 link_clk = ~link_clk;
   end
   always @(posedge link_clk) if (lk_nack === 1'b1) nacks++;
   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         stop_test;
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one command: frame out, target answers, reply compared with model
   task automatic run(input int op);
      logic [31:0] a, d, r;
      logic [7:0]  q[$];
      logic [7:0]  st;
      logic        rd, ee, c, bad;
      int          nk;
      a = rnd();
      d = rnd();
      r = rnd();
      rd = op[0];
      ee = op[1];
      bad = op[2];
      c = r[9];
      nk = nacks;
      // malformed case: block register write with a short length byte
      if (bad) a[31] = 1'b1;
      q.push_back({1'b0, a[31], a[30] & ~a[31], 2'h0, ee, 2'h3});
      if (a[31]) q.push_back(ee ? 8'h05 - rd :
                             (rd ? 8'h03 : 8'h07 - bad));
      q.push_back(ee ? {6'h0, a[29], rd} : {3'h0, rd, a[3:0]});
      if (ee) q.push_back({a[22:16], 1'b0});
      q.push_back(a[7:0]);
      q.push_back(ee ? a[15:8] : {2'h0, a[13:8]});
      for (int i = 0; i < (rd ? 0 : ee ? 1 : 4); i++) q.push_back(d[8*i +: 8]);
      host.send(q);
      if (op == 1) host.send('{8'h00});
      // a malformed frame gets no access, so no target answer is given
      if (!bad) begin
         for (int i = 0; i < 400 && !(reg_req | ee_req); i++)
            @(negedge ref_clk);
         if (ee) begin
            check({ee_req, ee_rd, ee_dev_addr, ee_addr},
               {1'b1, rd, a[29] ? a[22:16] : cfg_ee_dev_addr, a[15:0]});
            if (!rd) check(ee_wdata, d[7:0]);
         end else begin
            check({reg_req, reg_wr, reg_be, reg_addr},
               {1'b1, ~rd, a[3:0], a[13:0]});
            if (!rd) check(reg_wdata, d);
         end
         check(lk_busy, 1'b1);
         // clear pulse lands with the answer, so set must win
         @(posedge ref_clk);
         {reg_ack, ee_done, reg_claimed, ee_nack} <= {~ee, ee, c, c};
         {ee_misplaced, reg_rdata, ee_rdata} <= {r[10], r, r[7:0]};
         ee_err_clr <= {2{ee & a[28]}};
         @(posedge ref_clk);
         {reg_ack, ee_done, ee_err_clr} <= 4'h0;
      end
      if (ee && a[28]) {nak, oth} = 2'h0;
      if (!ee && rd) read_unclaimed_flag = ~c;
      if (!ee && !rd) write_unclaimed_flag = ~c | bad;
      nak |= ee & c;
      oth |= ee & r[10];
      st = ee ? {2'h0, oth, 1'b0, nak, 1'b0, a[29], rd}
              : {write_unclaimed_flag, read_unclaimed_flag, 1'b0, rd, a[3:0]};
      do @(posedge link_clk) #1; while (lk_resp_valid !== 1'b1);
      check(lk_status, st);
      check(ee ? ee_status : csr_status, st);
      check({reg_req, ee_req, lk_busy}, 3'h0);
      if (rd) check(ee ? lk_rdata[7:0] : lk_rdata, ee ? r[7:0] : r);
      check(nacks - nk, op == 1);
   endtask
   initial begin
      {srst, reg_ack, reg_claimed, ee_done, ee_nack, ee_misplaced} = 6'h20;
      {reg_rdata, ee_rdata, ee_err_clr} = '0;
      cfg_ee_dev_addr = 7'h2a;
      {write_unclaimed_flag, read_unclaimed_flag, nak, oth} = 4'h0;
      repeat (16) @(posedge ref_clk);
      repeat (4) @(posedge link_clk);
      @(posedge ref_clk);
      srst <= 1'b0;
      repeat (3) @(posedge link_clk);
      for (int k = 0; k < 25; k++) run(k % 5);
      stop_test;
   end
endmodule
